/* verilog/cpu_regfile.sv */
// Contract
// RULE1 - Ports: 1 or 2 byte reads, byte or 16-bit writes, 16-bit pair read.
// RULE2 - General registers mapped at data addresses 0..31.
// RULE3 - Pointer-addressed data access in 0..31 hits the general register; the code only stores there, loads return 0x00.
// RULE4 - Registers 26..31 form X, Y, Z 16-bit pointers, still byte usable.
// RULE5 - Pointer access supports displacement, post-increment, pre-decrement.
// RULE6 - Stack grows downward; pointer marks top of stack.
// RULE7 - Push decrements stack pointer by one, pop increments by one.
// RULE8 - Call or interrupt entry subtracts two; returns add two.
// RULE9 - Stack pointer resets to 0x8FF.
// RULE10 - Software sets up the stack above SRAM start before calls.
// RULE11 - Stack pointer low byte at data 0x5D / I/O 0x3D, high next.
// RULE12 - Stack pointer bits 15..12 read zero and ignore writes.
// RULE13 - Short I/O 0x00..0x3F equals data address plus 0x20.
// RULE14 - Data addresses 0x60 and up unreachable by short I/O.
// RULE15 - Low-byte write goes to temp; high write commits both together.
// RULE16 - Low-byte read captures high byte into temp; high read returns it.
// RULE17 - Software accesses low byte before high byte.
// RULE18 - Temporary register directly readable and writable.
// RULE19 - Software may mask interrupts around two-byte accesses.
// RULE20 - Core runs straight from clk_sys, no division.
// RULE21 - Fetch overlaps execute for one instruction per clock.
// RULE22 - Two-operand ALU read, execute, write-back in one cycle.
// RULE23 - A write is visible to reads the next cycle.
module cpu_regfile (
    input  wire logic        clk_sys,        // Core clock, undivided
    input  wire logic        sys_rst,        // Async reset, active high
    input  wire logic [4:0]  rd_a_addr,      // Operand A register
    input  wire logic [4:0]  rd_b_addr,      // Operand B register
    input  wire logic        rd_pair,        // Operand A read as 16-bit pair
    input  wire logic        wr_en,          // Result write strobe
    input  wire logic        wr_wide,        // Result is 16-bit
    input  wire logic [4:0]  wr_addr,        // Result register
    input  wire logic [15:0] wr_data,        // Result data
    input  wire logic        mem_en,         // Data-space access strobe
    input  wire logic        mem_we,         // Data-space write
    input  wire logic        mem_io,         // Short I/O form
    input  wire logic [15:0] mem_addr,       // Direct data/io address
    input  wire core_regs_pkg::ptr_sel_t  ptr_sel,  // Pointer addressing
    input  wire core_regs_pkg::ptr_mode_t ptr_mode, // Pointer mode
    input  wire logic [5:0]  ptr_disp,       // Fixed displacement
    input  wire logic [7:0]  mem_wdata,      // Store data
    input  wire core_regs_pkg::stack_op_t stack_op, // Stack pointer update
    output logic      [15:0] rd_a_data,      // Operand A (pair when rd_pair)
    output logic      [7:0]  rd_b_data,      // Operand B
    output logic      [15:0] eff_addr,       // Resolved data address
    output logic             ext_sel,        // Access goes outside this block
    output logic      [7:0]  mem_rdata,      // Load data
    output logic      [15:0] stack_top       // Current stack pointer
);

    // ==========================================================
    // Register array
    // ==========================================================
    gpr_port_if gp ();

    gpr_array #(.DEPTH(32)) u_gpr (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .bus     (gp)
    );

    // ==========================================================
    // Address resolution
    // ==========================================================
    function automatic logic [4:0] ptr_low(input core_regs_pkg::ptr_sel_t s);
        case (s)
            core_regs_pkg::PTR_X: ptr_low = core_regs_pkg::PTR_X_LOW;
            core_regs_pkg::PTR_Y: ptr_low = core_regs_pkg::PTR_Y_LOW;
            default:              ptr_low = core_regs_pkg::PTR_Z_LOW;
        endcase
    endfunction : ptr_low

    logic [15:0] sp_reg, sp_next;
    logic [7:0]  temp_reg, temp_next;
    logic [7:0]  ptr_lo, ptr_hi;
    logic [15:0] ptr_val, ptr_upd, addr_c;
    logic        use_ptr, ptr_wb;
    logic [7:0]  rdata_c;

    assign use_ptr = (ptr_sel != core_regs_pkg::PTR_NONE) && mem_en;
    // Both read ports borrow the pointer pair during pointer access, A the low byte and B the high byte
    assign ptr_lo  = gp.rd_a_data;
    assign ptr_hi  = gp.rd_b_data;
    assign ptr_val = {ptr_hi, ptr_lo};                                          // RULE4
    // Post-increment uses old value, pre-decrement uses new one
    assign ptr_upd = (ptr_mode == core_regs_pkg::PM_POSTINC) ? ptr_val + 16'h0001 :
                     ptr_val - 16'h0001;                                        // RULE5
    assign ptr_wb  = use_ptr && (ptr_mode != core_regs_pkg::PM_DISP);

    // Short I/O form limited to 6 bits, so 0x60 and up cannot be reached
    assign addr_c = !use_ptr ? (mem_io ? {10'h000, mem_addr[5:0]} + core_regs_pkg::IO_DATA_OFFSET
                                       : mem_addr) :                            // RULE13 RULE14
                    (ptr_mode == core_regs_pkg::PM_DISP) ? ptr_val + {10'h000, ptr_disp} :
                    (ptr_mode == core_regs_pkg::PM_PREDEC) ? ptr_upd : ptr_val; // RULE5

    logic hit_gpr, hit_spl, hit_sph, hit_tmp;
    assign hit_gpr = addr_c <= core_regs_pkg::GPR_SPACE_TOP;                    // RULE2 RULE3
    assign hit_spl = addr_c == core_regs_pkg::SP_LOW_DATA_ADDR;                 // RULE11
    assign hit_sph = addr_c == core_regs_pkg::SP_HIGH_DATA_ADDR;                // RULE11
    assign hit_tmp = addr_c == core_regs_pkg::TEMP_DATA_ADDR;                   // RULE18

    // ==========================================================
    // Register array port steering
    // ==========================================================
    logic gpr_st;
    assign gpr_st = mem_en && mem_we && hit_gpr;
    assign gp.rd_a_addr = use_ptr ? ptr_low(ptr_sel) :
                          rd_pair ? {rd_a_addr[4:1], 1'b0} : rd_a_addr;         // RULE1
    assign gp.rd_b_addr = use_ptr ? ptr_low(ptr_sel) + 5'h01 :
                          rd_pair ? {rd_a_addr[4:1], 1'b1} : rd_b_addr;         // RULE1
    // Pointer reads take both ports, so the load data path never reads the array; loads in 0..31 return 0x00
    // Store has its own port so a pointer store and its writeback land together
    assign gp.wr_st_en   = gpr_st;                                              // RULE3
    assign gp.wr_st_addr = addr_c[4:0];
    assign gp.wr_st_data = mem_wdata;
    assign gp.wr_lo_en   = (wr_en && !gpr_st) || ptr_wb;
    assign gp.wr_lo_addr = ptr_wb ? ptr_low(ptr_sel) : wr_wide ? {wr_addr[4:1], 1'b0} : wr_addr;
    assign gp.wr_lo_data = ptr_wb ? ptr_upd[7:0] : wr_data[7:0];
    assign gp.wr_hi_en   = ptr_wb || (wr_en && wr_wide && !gpr_st);             // RULE1
    assign gp.wr_hi_data = ptr_wb ? ptr_upd[15:8] : wr_data[15:8];

    // ==========================================================
    // Stack pointer and temporary byte
    // ==========================================================
    logic [15:0] sp_step;
    always_comb
    begin
        sp_next   = sp_reg;
        temp_next = temp_reg;
        case (stack_op)
            core_regs_pkg::SOP_PUSH: sp_next = sp_reg - core_regs_pkg::SP_STEP_BYTE; // RULE6 RULE7
            core_regs_pkg::SOP_POP:  sp_next = sp_reg + core_regs_pkg::SP_STEP_BYTE; // RULE7
            core_regs_pkg::SOP_CALL: sp_next = sp_reg - core_regs_pkg::SP_STEP_WORD; // RULE8
            core_regs_pkg::SOP_RET:  sp_next = sp_reg + core_regs_pkg::SP_STEP_WORD; // RULE8
            default:                 sp_next = sp_reg;
        endcase
        if (mem_en && mem_we && hit_spl)
            temp_next = mem_wdata;                                              // RULE15
        if (mem_en && mem_we && hit_sph)
            sp_next = {mem_wdata, temp_reg};                                    // RULE15
        if (mem_en && !mem_we && hit_spl)
            temp_next = sp_reg[15:8];                                           // RULE16
        if (mem_en && mem_we && hit_tmp)
            temp_next = mem_wdata;                                              // RULE18
        sp_next = sp_next & core_regs_pkg::SP_WRITE_MASK;                       // RULE12
    end
    assign sp_step = sp_next;

    always_comb
    begin
        rdata_c = 8'h00;
        if (hit_spl)
            rdata_c = sp_reg[7:0];
        else if (hit_sph || hit_tmp)
            rdata_c = temp_reg;                                                 // RULE16 RULE18
    end

    // SP held in a flop straight from reset, fixed value; clocked by the undivided core clock RULE20
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sp_reg   <= core_regs_pkg::SP_RESET_VALUE;                          // RULE9
            temp_reg <= 8'h00;
        end
        else
        begin
            sp_reg   <= sp_step;
            temp_reg <= temp_next;
        end
    end

    // ==========================================================
    // Registered outputs, one cycle behind the request
    // ==========================================================
    // Array write lands at the edge, so next-cycle reads see it without stall
    // One new request accepted every edge RULE21
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_a_data <= 16'h0000;
            rd_b_data <= 8'h00;
            eff_addr  <= 16'h0000;
            ext_sel   <= 1'b0;
            mem_rdata <= 8'h00;
            stack_top <= core_regs_pkg::SP_RESET_VALUE;
        end
        else
        begin
            rd_a_data <= rd_pair ? {gp.rd_b_data, gp.rd_a_data} : {8'h00, gp.rd_a_data}; // RULE1 RULE22
            rd_b_data <= gp.rd_b_data;
            eff_addr  <= addr_c;
            ext_sel   <= mem_en && !(hit_gpr || hit_spl || hit_sph || hit_tmp);
            mem_rdata <= rdata_c;
            stack_top <= sp_step;                                               // RULE23
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_sp_reset;
        @(posedge clk_sys) $fell(sys_rst) |-> stack_top == 16'h08ff;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("sp reset value wrong"); // RULE9

    property p_push;
        @(posedge clk_sys) disable iff (sys_rst)
        (stack_op == core_regs_pkg::SOP_PUSH && !mem_en) |=> sp_reg == (($past(sp_reg) - 16'h0001) & 16'h0fff);
    endproperty
    a_push: assert property (p_push) else $error("push step wrong"); // RULE7

    property p_call;
        @(posedge clk_sys) disable iff (sys_rst)
        (stack_op == core_regs_pkg::SOP_CALL && !mem_en) |=> sp_reg == (($past(sp_reg) - 16'h0002) & 16'h0fff);
    endproperty
    a_call: assert property (p_call) else $error("call step wrong"); // RULE8

    property p_ret;
        @(posedge clk_sys) disable iff (sys_rst)
        (stack_op == core_regs_pkg::SOP_RET && !mem_en) |=> sp_reg == (($past(sp_reg) + 16'h0002) & 16'h0fff);
    endproperty
    a_ret: assert property (p_ret) else $error("return step wrong"); // RULE8

    property p_sp_top;
        @(posedge clk_sys) disable iff (sys_rst) sp_reg[15:12] == 4'h0;
    endproperty
    a_sp_top: assert property (p_sp_top) else $error("sp upper bits set"); // RULE12

    property p_hi_commit;
        @(posedge clk_sys) disable iff (sys_rst)
        (mem_en && mem_we && hit_sph && stack_op == core_regs_pkg::SOP_NONE)
        |=> sp_reg[7:0] == $past(temp_reg);
    endproperty
    a_hi_commit: assert property (p_hi_commit) else $error("temp not committed"); // RULE15

    property p_lo_capture;
        @(posedge clk_sys) disable iff (sys_rst)
        (mem_en && !mem_we && hit_spl) |=> temp_reg == $past(sp_reg[15:8]);
    endproperty
    a_lo_capture: assert property (p_lo_capture) else $error("high byte not captured"); // RULE16

    property p_io_map;
        @(posedge clk_sys) disable iff (sys_rst)
        (mem_en && mem_io && !use_ptr) |-> addr_c < core_regs_pkg::EXT_IO_BASE;
    endproperty
    a_io_map: assert property (p_io_map) else $error("io reached ext space"); // RULE14

    property p_wr_visible;
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_en && !wr_wide && !gpr_st && !ptr_wb) ##1 (!use_ptr && rd_b_addr == $past(wr_addr) && !rd_pair)
        |=> rd_b_data == $past(wr_data[7:0], 2);
    endproperty
    a_wr_visible: assert property (p_wr_visible) else $error("write not visible"); // RULE23 RULE22

endmodule : cpu_regfile

/* verilog/core_regs_pkg.sv */
package core_regs_pkg;

    // ==========================================================
    // Data-space map
    // ==========================================================
    localparam logic [15:0] GPR_SPACE_TOP     = 16'h001f;  // Last register-mapped address
    localparam logic [15:0] IO_DATA_OFFSET    = 16'h0020;  // Short I/O address + this = data address
    localparam logic [5:0]  IO_ADDR_MAX       = 6'h3f;     // Highest short I/O address
    localparam logic [15:0] EXT_IO_BASE       = 16'h0060;  // Data-space-only region start
    localparam logic [15:0] SP_LOW_DATA_ADDR  = 16'h005d;  // Stack pointer low byte
    localparam logic [15:0] SP_HIGH_DATA_ADDR = 16'h005e;  // Stack pointer high byte
    localparam logic [5:0]  SP_LOW_IO_ADDR    = 6'h3d;     // Same byte in short I/O space
    localparam logic [15:0] TEMP_DATA_ADDR    = 16'h005c;  // Directly accessible temporary byte

    // ==========================================================
    // Stack pointer
    // ==========================================================
    localparam logic [15:0] SP_RESET_VALUE = 16'h08ff;     // Last internal SRAM address
    localparam logic [15:0] SP_WRITE_MASK  = 16'h0fff;     // Bits 11..0 writable
    localparam logic [15:0] SP_STEP_BYTE   = 16'h0001;     // Push / pop
    localparam logic [15:0] SP_STEP_WORD   = 16'h0002;     // Call / return

    // ==========================================================
    // Pointer pairs in the upper six general registers
    // ==========================================================
    localparam logic [4:0] PTR_X_LOW = 5'h1a;
    localparam logic [4:0] PTR_Y_LOW = 5'h1c;
    localparam logic [4:0] PTR_Z_LOW = 5'h1e;

    typedef enum logic [1:0] {PTR_NONE, PTR_X, PTR_Y, PTR_Z} ptr_sel_t;
    typedef enum logic [1:0] {PM_DISP, PM_POSTINC, PM_PREDEC} ptr_mode_t;
    typedef enum logic [2:0] {SOP_NONE, SOP_PUSH, SOP_POP, SOP_CALL, SOP_RET} stack_op_t;

endpackage : core_regs_pkg

/* verilog/gpr_port_if.sv */
interface gpr_port_if;
    logic [4:0] rd_a_addr;
    logic [4:0] rd_b_addr;
    logic [7:0] rd_a_data;
    logic [7:0] rd_b_data;
    logic       wr_lo_en;
    logic [4:0] wr_lo_addr;
    logic [7:0] wr_lo_data;
    logic       wr_hi_en;
    logic [7:0] wr_hi_data;
    logic       wr_st_en;
    logic [4:0] wr_st_addr;
    logic [7:0] wr_st_data;

    modport core (output rd_a_addr, rd_b_addr, wr_lo_en, wr_lo_addr, wr_lo_data,
                  wr_hi_en, wr_hi_data, wr_st_en, wr_st_addr, wr_st_data, input rd_a_data, rd_b_data);
    modport store (input rd_a_addr, rd_b_addr, wr_lo_en, wr_lo_addr, wr_lo_data,
                   wr_hi_en, wr_hi_data, wr_st_en, wr_st_addr, wr_st_data, output rd_a_data, rd_b_data);
endinterface : gpr_port_if

/* verilog/gpr_array.sv */
module gpr_array #(
    parameter int DEPTH = 32
) (
    input  wire logic clk_sys,   // Core clock
    input  wire logic sys_rst,   // Async reset
    gpr_port_if.store bus        // Read and write ports
);

    // ==========================================================
    // Storage with two combinational read ports
    // ==========================================================
    logic [7:0] mem_reg [DEPTH];

    // Reads are same-cycle so operand read, execute and write fit in one clock
    assign bus.rd_a_data = mem_reg[bus.rd_a_addr];
    assign bus.rd_b_data = mem_reg[bus.rd_b_addr];

    // Byte write, or 16-bit write to an even/odd pair
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_reg[i] <= 8'h00;
        end
        else
        begin
            // Data-space store first, so pointer writeback overrides it; the core gates result writes off during a store
            if (bus.wr_st_en)
                mem_reg[bus.wr_st_addr] <= bus.wr_st_data;
            if (bus.wr_lo_en)
                mem_reg[bus.wr_lo_addr] <= bus.wr_lo_data;
            if (bus.wr_hi_en)
                mem_reg[{bus.wr_lo_addr[4:1], 1'b1}] <= bus.wr_hi_data;
        end
    end

endmodule : gpr_array

/* test/core_issuer.sv */
// ==========================================================
// Decoder side: one operation per core clock
// ==========================================================
module core_issuer (
    input  wire logic                clk_sys,   // Core clock
    output logic [4:0]               rd_a_addr, // Operand A index
    output logic [4:0]               rd_b_addr, // Operand B index
    output logic                     rd_pair,   // Pair read
    output logic                     wr_en,     // Result write
    output logic                     wr_wide,   // 16-bit result
    output logic [4:0]               wr_addr,   // Result index
    output logic [15:0]              wr_data,   // Result value
    output logic                     mem_en,    // Data access
    output logic                     mem_we,    // Store
    output logic                     mem_io,    // Short I/O form
    output logic [15:0]              mem_addr,  // Direct address
    output core_regs_pkg::ptr_sel_t  ptr_sel,   // Pointer choice
    output core_regs_pkg::ptr_mode_t ptr_mode,  // Pointer mode
    output logic [5:0]               ptr_disp,  // Displacement
    output logic [7:0]               mem_wdata, // Store data
    output core_regs_pkg::stack_op_t stack_op   // Stack update
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus from time zero; no interrupts, so byte pairs are never split
    initial
    begin
        {rd_a_addr, rd_b_addr, rd_pair, wr_en, wr_wide, wr_addr, wr_data} = '0;
        {mem_en, mem_we, mem_io, mem_addr, ptr_disp, mem_wdata} = '0;
        ptr_sel = core_regs_pkg::PTR_NONE;
        ptr_mode = core_regs_pkg::PM_DISP;
        stack_op = core_regs_pkg::SOP_NONE;
    end

    // Drive at the falling edge, hold across the sampling edge; every field set once
    task automatic put(input logic [4:0] ra, rb, input logic pr, we, ww, input logic [4:0] wa, input logic [15:0] wd,
                       input logic me, mw, mi, input logic [15:0] ma, input core_regs_pkg::ptr_sel_t ps,
                       input core_regs_pkg::ptr_mode_t pm, input logic [5:0] pd, input logic [7:0] md,
                       input core_regs_pkg::stack_op_t so);
        {rd_a_addr, rd_b_addr, rd_pair, wr_en, wr_wide, wr_addr, wr_data} = {ra, rb, pr, we, ww, wa, wd};
        {mem_en, mem_we, mem_io, mem_addr, ptr_disp, mem_wdata} = {me, mw, mi, ma, pd, md};
        ptr_sel = ps;
        ptr_mode = pm;
        stack_op = so;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : put

    task automatic alu(input logic [4:0] ra, rb, input logic pr, we, ww, input logic [4:0] wa, input logic [15:0] wd);
        put(ra, rb, pr, we, ww, wa, wd, 1'b0, 1'b0, 1'b0, 16'h0000, core_regs_pkg::PTR_NONE, core_regs_pkg::PM_DISP,
            6'h00, 8'h00, core_regs_pkg::SOP_NONE);
    endtask : alu

    task automatic mem(input logic mw, mi, input logic [15:0] ma, input logic [7:0] md);
        put(5'h00, 5'h00, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000, 1'b1, mw, mi, ma, core_regs_pkg::PTR_NONE,
            core_regs_pkg::PM_DISP, 6'h00, md, core_regs_pkg::SOP_NONE);
    endtask : mem

    task automatic ptr(input core_regs_pkg::ptr_sel_t ps, input core_regs_pkg::ptr_mode_t pm, input logic [7:0] md);
        put(5'h00, 5'h00, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000, 1'b1, 1'b1, 1'b0, 16'h0000, ps, pm, 6'h3f, md,
            core_regs_pkg::SOP_NONE);
    endtask : ptr

    task automatic stk(input core_regs_pkg::stack_op_t so);
        put(5'h00, 5'h00, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, core_regs_pkg::PTR_NONE,
            core_regs_pkg::PM_DISP, 6'h00, 8'h00, so);
    endtask : stk

    // Low byte always first, else the high write would commit a stale temp
    task automatic sp_write(input logic io, input logic [15:0] v);
        mem(1'b1, io, io ? 16'h003d : 16'h005d, v[7:0]);
        mem(1'b1, io, io ? 16'h003e : 16'h005e, v[15:8]);
    endtask : sp_write
endmodule : core_issuer

/* test/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Wiring and model state
    // ==========================================================
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] rd_a_addr, rd_b_addr, wr_addr;
    logic rd_pair, wr_en, wr_wide, mem_en, mem_we, mem_io, ext_sel;
    logic [15:0] wr_data, mem_addr, rd_a_data, eff_addr, stack_top;
    logic [7:0] rd_b_data, mem_wdata, mem_rdata;
    logic [5:0] ptr_disp;
    core_regs_pkg::ptr_sel_t ptr_sel;
    core_regs_pkg::ptr_mode_t ptr_mode;
    core_regs_pkg::stack_op_t stack_op;
    int err_count = 0;
    int n_checks = 0;
    int g[32];
    int sp, ra, rb, wa, wd, pa, ea, dv;

    // Core clock, 200 MHz
    always #2.5 clk_sys = ~clk_sys;

    cpu_regfile i_dut (.clk_sys, .sys_rst, .rd_a_addr, .rd_b_addr, .rd_pair, .wr_en, .wr_wide, .wr_addr, .wr_data,
        .mem_en, .mem_we, .mem_io, .mem_addr, .ptr_sel, .ptr_mode, .ptr_disp, .mem_wdata, .stack_op,
        .rd_a_data, .rd_b_data, .eff_addr, .ext_sel, .mem_rdata, .stack_top);
    core_issuer i_dec (.clk_sys, .rd_a_addr, .rd_b_addr, .rd_pair, .wr_en, .wr_wide, .wr_addr, .wr_data,
        .mem_en, .mem_we, .mem_io, .mem_addr, .ptr_sel, .ptr_mode, .ptr_disp, .mem_wdata, .stack_op);

    // ==========================================================
    // Compare and report
    // ==========================================================
    task automatic chk_val(input logic [15:0] act, input logic [15:0] exp, input string what);
        n_checks++;
        if (act !== exp)
        begin
            err_count++;
            $display("BAD %0t %s got %h want %h", $time, what, act, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic act, input logic exp, input string what);
        chk_val({15'h0000, act}, {15'h0000, exp}, what);
    endtask : chk_flag

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Model of a result write; wide writes land on the even/odd pair
    task automatic mwr(input int a, input int d, input logic w);
        if (w)
        begin
            g[a & 30] = d & 255;
            g[a | 1] = (d >> 8) & 255;
        end
        else
            g[a] = d & 255;
    endtask : mwr

    // Generous limit; the sequence needs about 125 cycles
    initial
    begin
        #20000;
        err_count++;
        tally_and_finish();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        void'($urandom(57));
        sp = 16'h08ff;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        chk_val(stack_top, 16'h08ff, "sp reset");
        i_dec.mem(1'b0, 1'b0, 16'h005d, 8'h00);
        chk_val({8'h00, mem_rdata}, 16'h00ff, "sp low read");
        i_dec.mem(1'b0, 1'b0, 16'h005e, 8'h00);
        chk_val({8'h00, mem_rdata}, 16'h0008, "sp high read");
        // Dependent back-to-back ops: each reads what the previous one wrote
        pa = 0;
        for (int i = 0; i < 64; i++)
        begin
            ra = pa;
            rb = $urandom % 32;
            wa = $urandom % 32;
            wd = $urandom % 65536;
            i_dec.alu(ra[4:0], rb[4:0], i % 3 == 0, 1'b1, i % 4 == 0, wa[4:0], wd[15:0]);
            dv = (i % 3 == 0) ? ((g[ra | 1] << 8) | g[ra & 30]) : g[ra];
            if (((wa | 1) != (ra | 1)) && ((wa | 1) != (rb | 1)))
            begin
                chk_val(rd_a_data, dv[15:0], "operand a");
                if (i % 3 != 0)
                    chk_val({8'h00, rd_b_data}, g[rb][15:0], "operand b");
            end
            mwr(wa, wd, i % 4 == 0);
            pa = wa;
        end
        // Direct data-space store into a general register
        i_dec.mem(1'b1, 1'b0, 16'h0007, 8'hc3);
        g[7] = 195;
        chk_flag(ext_sel, 1'b0, "register space local");
        i_dec.alu(5'h07, 5'h00, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000);
        chk_val(rd_a_data, 16'h00c3, "mapped register");
        // Pointers: X post-increment, Y pre-decrement, Z displacement
        for (int k = 0; k < 3; k++)
        begin
            pa = (k == 0) ? 3 : ((k == 1) ? 16 : 256);
            i_dec.alu(5'h00, 5'h00, 1'b0, 1'b1, 1'b1, 5'(26 + 2 * k), pa[15:0]);
            mwr(26 + 2 * k, pa, 1'b1);
            ea = (k == 0) ? pa : ((k == 1) ? pa - 1 : pa + 63);
            i_dec.ptr(core_regs_pkg::ptr_sel_t'(k + 1), core_regs_pkg::ptr_mode_t'((k + 1) % 3), 8'(165 + k));
            chk_val(eff_addr, ea[15:0], "pointer address");
            chk_flag(ext_sel, ea > 95, "pointer target");
            if (ea < 32)
                g[ea] = 165 + k;
            dv = (k == 0) ? pa + 1 : ((k == 1) ? pa - 1 : pa);
            mwr(26 + 2 * k, dv, 1'b1);
            i_dec.alu(5'(26 + 2 * k), 5'h00, 1'b1, 1'b0, 1'b0, 5'h00, 16'h0000);
            chk_val(rd_a_data, dv[15:0], "pointer update");
            i_dec.alu(5'(ea & 31), 5'h00, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000);
            chk_val(rd_a_data, g[ea & 31][15:0], "indirect store");
        end
        // Short I/O form folds into 0x20..0x5F only
        for (int k = 0; k < 3; k++)
        begin
            i_dec.mem(1'b0, 1'b1, 16'(k * 63), 8'h00);
            ea = ((k * 63) & 63) + 32;
            chk_val(eff_addr, ea[15:0], "io address");
            chk_flag(ext_sel, ea < 92 || ea > 94, "io target");
        end
        i_dec.mem(1'b0, 1'b0, 16'h0060, 8'h00);
        chk_flag(ext_sel, 1'b1, "extended io");
        // Random stack steps
        for (int i = 0; i < 24; i++)
        begin
            wa = $urandom % 5;
            i_dec.stk(core_regs_pkg::stack_op_t'(wa));
            sp = sp + ((wa == 1) ? -1 : ((wa == 2) ? 1 : ((wa == 3) ? -2 : ((wa == 4) ? 2 : 0))));
            chk_val(stack_top, sp[15:0], "stack step");
        end
        // Byte-wise stack pointer writes and atomic reads
        i_dec.mem(1'b1, 1'b0, 16'h005d, 8'h23);
        chk_val(stack_top, sp[15:0], "low byte held");
        i_dec.mem(1'b1, 1'b0, 16'h005e, 8'hf1);
        chk_val(stack_top, 16'h0123, "high commit");
        i_dec.sp_write(1'b1, 16'h0800);
        chk_val(stack_top, 16'h0800, "io write");
        i_dec.mem(1'b0, 1'b0, 16'h005d, 8'h00);
        chk_val({8'h00, mem_rdata}, 16'h0000, "low read");
        i_dec.put(5'h00, 5'h00, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h005e,
            core_regs_pkg::PTR_NONE, core_regs_pkg::PM_DISP, 6'h00, 8'h00, core_regs_pkg::SOP_PUSH);
        chk_val({8'h00, mem_rdata}, 16'h0008, "captured high");
        chk_val(stack_top, 16'h07ff, "push during read");
        i_dec.mem(1'b1, 1'b0, 16'h005c, 8'h77);
        i_dec.mem(1'b1, 1'b0, 16'h005e, 8'h03);
        chk_val(stack_top, 16'h0377, "temp commit");
        i_dec.mem(1'b0, 1'b0, 16'h005c, 8'h00);
        chk_val({8'h00, mem_rdata}, 16'h0077, "temp read");
        tally_and_finish();
    end
endmodule : tb
